/* rtl/mev_event_block.sv */
// motor event block: timers, full compares with deadband, capture and quadrature decoder
// Functional notes
// RL1 - two 16-bit up/down timers, software readable/writable
// RL2 - timer compare double-buffered via shadow copy
// RL3 - timer period double-buffered via shadow copy
// RL4 - four maskable timer events: underflow, overflow, compare, period
// RL5 - directional mode takes direction from pin
// RL6 - internal or external clock, then prescaler
// RL7 - three continuous modes: up, up/down, directional
// RL8 - timers run independently or started together
// RL9 - timer 1 drives compares; timer 2/1 captures
// RL10 - three compare units drive six configurable outputs
// RL11 - full compare values double-buffered
// RL12 - three 8-bit dead counters, shared 8-bit value
// RL13 - deadband enabled per compare unit
// RL14 - complementary output pair per compare unit
// RL15 - output action register double-buffered
// RL16 - eight pwm outputs: three pairs plus two
// RL17 - inserted deadband never shorter than 50 ns
// RL18 - protection input raises maskable interrupt
// RL19 - capture stores timer count into two-entry fifo
// RL20 - capture needs level stable two clock edges
// RL21 - capture edge select, own maskable flag
// RL22 - quadrature decoder counts timer 2, four per cycle
// RL23 - full fifo drops oldest, records overflow
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mev_event_block
  import mev_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [1:0] timer_clk_ext_i,
  input wire logic [1:0] count_direction_input_i,
  input wire logic power_protect_n_i,
  input wire logic [2:0] capture_input_i,
  output logic [5:0] pwm_pair_o,
  output logic [1:0] timer_pwm_o,
  output logic irq_o
);
  import mev_pkg::*;

  typedef struct packed {
    logic awrdy;
    logic wrdy;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [1:0][15:0] cnt;
    logic [1:0][15:0] cmp_sh;
    logic [1:0][15:0] cmp_act;
    logic [1:0][15:0] per_sh;
    logic [1:0][15:0] per_act;
    logic [1:0] up;
    logic [1:0][15:0] ctl;
    logic [1:0][6:0] psc;
    logic [1:0] tclk_d;
    logic [2:0][15:0] fcmp_sh;
    logic [2:0][15:0] fcmp_act;
    logic [11:0] output_action_register_sh;
    logic [11:0] output_action_register_act;
    logic [10:0] dbctl;
    logic [2:0][7:0] dbcnt;
    logic [2:0][3:0] dbsub;
    logic [2:0] raw;
    logic [10:0] capctl;
    logic [2:0] cs0;
    logic [2:0] cs1;
    logic [2:0] cs2;
    logic [2:0] lvl;
    logic [2:0][1:0][15:0] fifo;
    logic [2:0][1:0] fcnt;
    logic [2:0] fovf;
    logic [11:0] flags;
    logic [11:0] mask;
    logic pdp_d;
    logic [5:0] pwm;
    logic [1:0] tpwm;
    logic irq;
  } mev_state_t;

  mev_state_t s_reg;
  mev_state_t s_next;

  // byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
    merge16 = old;
    if (be[0]) merge16[7:0] = d[7:0];
    if (be[1]) merge16[15:8] = d[15:8];
  endfunction : merge16

  // one count step: returns {direction up, new count}
  function automatic logic [16:0] timer_step(input logic [15:0] c, input logic [15:0] per,
                                             input logic up, input logic [1:0] mode,
                                             input logic pin_up);
    logic [15:0] n;
    logic u;
    n = c;
    u = up;
    unique case (mode)
      MODE_CONT_UP:
      begin
        u = 1'b1;
        n = (c >= per) ? ZERO16 : c + 16'h0001;
      end
      MODE_CONT_UPDN:
      begin
        if (up) u = (c < per);
        else u = (c == ZERO16);
        n = u ? c + 16'h0001 : c - 16'h0001;
      end
      MODE_DIR_UPDN:
      begin
        u = pin_up; // RL5
        if (pin_up) n = (c >= per) ? ZERO16 : c + 16'h0001;
        else n = (c == ZERO16) ? per : c - 16'h0001;
      end
      MODE_STOP: n = c;
    endcase
    timer_step = {u, n};
  endfunction : timer_step

  // output action: 00 forced low, 01 active low, 10 active high, 11 forced high
  function automatic logic act_pol(input logic act, input logic [1:0] pol);
    unique case (pol)
      2'h0: act_pol = 1'b0;
      2'h1: act_pol = ~act;
      2'h2: act_pol = act;
      2'h3: act_pol = 1'b1;
    endcase
  endfunction : act_pol

  logic wr_fire;
  logic rd_fire;
  logic [7:0] wa;
  logic [7:0] ra;

  assign wr_fire = s_reg.awrdy & s_reg.wrdy;
  assign rd_fire = s_reg.arrdy;
  assign wa = s_axi_awaddr_i;
  assign ra = s_axi_araddr_i;

  always_comb
  begin
    logic [1:0] tick;
    logic [1:0] en;
    logic [16:0] st;
    logic [11:0] set;
    logic [11:0] clr;
    logic [1:0] qa;
    logic qinc;
    logic qdec;
    logic [15:0] capv;
    logic [2:0] acc;
    logic [2:0] pop;
    logic [2:0] dead;
    logic hi;
    logic lo;
    logic rhit;
    logic [2:0] ovf;
    s_next = s_reg;
    set = 12'h000;
    clr = 12'h000;
    tick = 2'h0;
    en = 2'h0;
    st = 17'h00000;
    qa = 2'h0;
    qinc = 1'b0;
    qdec = 1'b0;
    capv = ZERO16;
    acc = 3'h0;
    pop = 3'h0;
    dead = 3'h0;
    hi = 1'b0;
    lo = 1'b0;
    rhit = 1'b1;
    ovf = 3'h0;

    // capture input qualification: level must stand two edges
    s_next.cs0 = capture_input_i;
    s_next.cs1 = s_reg.cs0;
    s_next.cs2 = s_reg.cs1;
    acc = ~(s_reg.cs1 ^ s_reg.cs2) & (s_reg.cs2 ^ s_reg.lvl); // RL20
    s_next.lvl = s_reg.lvl ^ acc;

    // quadrature decoding on qualified inputs 1 and 2
    if (s_reg.capctl[CC_QEP])
    begin
      qa = acc[1:0];
      if (qa == 2'h1)
      begin
        qinc = s_next.lvl[0] != s_next.lvl[1]; // RL22
        qdec = ~qinc;
      end
      else if (qa == 2'h2)
      begin
        qinc = s_next.lvl[1] == s_next.lvl[0]; // RL22
        qdec = ~qinc;
      end
    end

    // timers
    s_next.tclk_d = timer_clk_ext_i;
    for (int i = 0; i < 2; i++)
    begin
      en[i] = s_reg.ctl[i][TC_ENABLE];
      if (i == 1 && s_reg.ctl[1][TC_SYNC]) en[1] = s_reg.ctl[0][TC_ENABLE]; // RL8
      if (en[i] && (!s_reg.ctl[i][TC_EXTCLK] || (timer_clk_ext_i[i] && !s_reg.tclk_d[i])))
      begin
        if (s_reg.psc[i] >= 7'((7'h01 << s_reg.ctl[i][TC_PSC_LSB +: 3]) - 7'h01)) // RL6
        begin
          s_next.psc[i] = 7'h00;
          tick[i] = 1'b1;
        end
        else s_next.psc[i] = s_reg.psc[i] + 7'h01;
      end
      if (i == 1 && s_reg.capctl[CC_QEP])
      begin
        tick[1] = qinc | qdec;
        st = timer_step(s_reg.cnt[1], s_reg.per_act[1], qinc, MODE_DIR_UPDN, qinc); // RL22
      end
      else
        st = timer_step(s_reg.cnt[i], s_reg.per_act[i], s_reg.up[i],
                        s_reg.ctl[i][TC_MODE_LSB +: 2], count_direction_input_i[i]); // RL7
      if (tick[i] && (s_reg.ctl[i][1:0] != MODE_STOP || (i == 1 && s_reg.capctl[CC_QEP])))
      begin
        s_next.up[i] = st[16];
        s_next.cnt[i] = st[15:0]; // RL1
        set[4 * i + FL_UNF] = st[15:0] == ZERO16; // RL4
        set[4 * i + FL_OVF] = st[15:0] == 16'hFFFF;
        set[4 * i + FL_CMP] = st[15:0] == s_reg.cmp_act[i];
        set[4 * i + FL_PER] = st[15:0] == s_reg.per_act[i];
        if (st[15:0] == ZERO16)
        begin
          s_next.cmp_act[i] = s_reg.cmp_sh[i]; // RL2
          s_next.per_act[i] = s_reg.per_sh[i]; // RL3
          if (i == 0)
          begin
            s_next.fcmp_act = s_reg.fcmp_sh; // RL11
            s_next.output_action_register_act = s_reg.output_action_register_sh; // RL15
          end
        end
      end
    end

    // protection input
    s_next.pdp_d = power_protect_n_i;
    set[FL_PDP] = s_reg.pdp_d & ~power_protect_n_i; // RL18

    // full compare with deadband, time base is timer 1
    for (int u = 0; u < 3; u++)
    begin
      s_next.raw[u] = s_reg.cnt[0] < s_reg.fcmp_act[u]; // RL9
      if (s_next.raw[u] != s_reg.raw[u])
      begin
        s_next.dbcnt[u] = (s_reg.dbctl[7:0] == 8'h00) ? 8'h01 : s_reg.dbctl[7:0]; // RL12
        s_next.dbsub[u] = 4'h0;
      end
      else if (s_reg.dbcnt[u] != 8'h00)
      begin
        if (s_reg.dbsub[u] == DB_SUB_LAST) // RL17
        begin
          s_next.dbsub[u] = 4'h0;
          s_next.dbcnt[u] = s_reg.dbcnt[u] - 8'h01;
        end
        else s_next.dbsub[u] = s_reg.dbsub[u] + 4'h1;
      end
      dead[u] = s_reg.dbctl[DB_EN_LSB + u] && s_reg.dbcnt[u] != 8'h00; // RL13
      hi = s_reg.raw[u] & ~dead[u]; // RL14
      lo = ~s_reg.raw[u] & ~dead[u];
      s_next.pwm[2 * u] = act_pol(hi, s_reg.output_action_register_act[4 * u +: 2]) & ~s_reg.flags[FL_PDP]; // RL10
      s_next.pwm[2 * u + 1] = act_pol(lo, s_reg.output_action_register_act[4 * u + 2 +: 2]) & ~s_reg.flags[FL_PDP];
    end
    for (int i = 0; i < 2; i++)
      s_next.tpwm[i] = s_reg.ctl[i][TC_OUT_EN] & ~s_reg.flags[FL_PDP] &
                       act_pol(s_reg.cnt[i] < s_reg.cmp_act[i],
                               s_reg.ctl[i][TC_POL_LSB +: 2]); // RL16

    // AXI handshake: ready raised for one cycle when a request waits
    s_next.awrdy = 1'b0;
    s_next.wrdy = 1'b0;
    if (s_axi_awvalid_i && s_axi_wvalid_i && !wr_fire && !s_reg.bvalid)
    begin
      s_next.awrdy = 1'b1;
      s_next.wrdy = 1'b1;
    end
    if (s_reg.bvalid && s_axi_bready_i) s_next.bvalid = 1'b0;
    s_next.arrdy = 1'b0;
    if (s_axi_arvalid_i && !s_reg.arrdy && !s_reg.rvalid) s_next.arrdy = 1'b1;
    if (s_reg.rvalid && s_axi_rready_i) s_next.rvalid = 1'b0;

    // register reads
    if (rd_fire)
    begin
      s_next.rvalid = 1'b1;
      s_next.rdata = 32'h00000000;
      unique case (ra)
        T1_CNT_OFS: s_next.rdata[15:0] = s_reg.cnt[0];
        T1_CMP_OFS: s_next.rdata[15:0] = s_reg.cmp_sh[0];
        T1_PER_OFS: s_next.rdata[15:0] = s_reg.per_sh[0];
        T1_CTL_OFS: s_next.rdata[15:0] = s_reg.ctl[0];
        T2_CNT_OFS: s_next.rdata[15:0] = s_reg.cnt[1];
        T2_CMP_OFS: s_next.rdata[15:0] = s_reg.cmp_sh[1];
        T2_PER_OFS: s_next.rdata[15:0] = s_reg.per_sh[1];
        T2_CTL_OFS: s_next.rdata[15:0] = s_reg.ctl[1];
        FCMP1_OFS: s_next.rdata[15:0] = s_reg.fcmp_sh[0];
        FCMP2_OFS: s_next.rdata[15:0] = s_reg.fcmp_sh[1];
        FCMP3_OFS: s_next.rdata[15:0] = s_reg.fcmp_sh[2];
        OUTPUT_ACTION_REGISTER_OFS: s_next.rdata[11:0] = s_reg.output_action_register_sh;
        DBCTL_OFS: s_next.rdata[10:0] = s_reg.dbctl;
        CAPCTL_OFS: s_next.rdata[10:0] = s_reg.capctl;
        CAPSTAT_OFS: s_next.rdata[8:0] = {s_reg.fovf, s_reg.fcnt[2], s_reg.fcnt[1], s_reg.fcnt[0]};
        CAPDAT1_OFS:
        begin
          s_next.rdata[15:0] = s_reg.fifo[0][0];
          pop[0] = 1'b1;
        end
        CAPDAT2_OFS:
        begin
          s_next.rdata[15:0] = s_reg.fifo[1][0];
          pop[1] = 1'b1;
        end
        CAPDAT3_OFS:
        begin
          s_next.rdata[15:0] = s_reg.fifo[2][0];
          pop[2] = 1'b1;
        end
        FLAG_OFS: s_next.rdata[11:0] = s_reg.flags;
        MASK_OFS: s_next.rdata[11:0] = s_reg.mask;
        default: rhit = 1'b0;
      endcase
      s_next.rresp = rhit ? RESP_OKAY : RESP_DECERR;
    end

    // capture fifos: pop first, then push; full fifo drops its oldest entry
    capv = s_reg.capctl[CC_TB_T1] ? s_reg.cnt[0] : s_reg.cnt[1]; // RL9
    for (int c = 0; c < 3; c++)
    begin
      if (pop[c] && s_reg.fcnt[c] != 2'h0)
      begin
        s_next.fifo[c][0] = s_reg.fifo[c][1];
        s_next.fcnt[c] = s_reg.fcnt[c] - 2'h1;
      end
      if (acc[c] && s_reg.capctl[CC_EN_LSB + c] && !(c < 2 && s_reg.capctl[CC_QEP]) &&
          s_reg.capctl[2 * c + (s_next.lvl[c] ? 0 : 1)]) // RL21
      begin
        set[FL_CAP_LSB + c] = 1'b1; // RL21
        if (s_next.fcnt[c] == 2'h2)
        begin
          s_next.fifo[c][0] = s_next.fifo[c][1]; // RL23
          s_next.fifo[c][1] = capv;
          s_next.fovf[c] = 1'b1; // RL23
          ovf[c] = 1'b1;
        end
        else
        begin
          s_next.fifo[c][s_next.fcnt[c][0]] = capv; // RL19
          s_next.fcnt[c] = s_next.fcnt[c] + 2'h1;
        end
      end
    end

    // register writes
    if (wr_fire)
    begin
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      unique case (wa)
        T1_CNT_OFS: s_next.cnt[0] = merge16(s_reg.cnt[0], s_axi_wdata_i, s_axi_wstrb_i);
        T1_CMP_OFS: s_next.cmp_sh[0] = merge16(s_reg.cmp_sh[0], s_axi_wdata_i, s_axi_wstrb_i);
        T1_PER_OFS: s_next.per_sh[0] = merge16(s_reg.per_sh[0], s_axi_wdata_i, s_axi_wstrb_i);
        T1_CTL_OFS: s_next.ctl[0] = merge16(s_reg.ctl[0], s_axi_wdata_i, s_axi_wstrb_i);
        T2_CNT_OFS: s_next.cnt[1] = merge16(s_reg.cnt[1], s_axi_wdata_i, s_axi_wstrb_i);
        T2_CMP_OFS: s_next.cmp_sh[1] = merge16(s_reg.cmp_sh[1], s_axi_wdata_i, s_axi_wstrb_i);
        T2_PER_OFS: s_next.per_sh[1] = merge16(s_reg.per_sh[1], s_axi_wdata_i, s_axi_wstrb_i);
        T2_CTL_OFS: s_next.ctl[1] = merge16(s_reg.ctl[1], s_axi_wdata_i, s_axi_wstrb_i);
        FCMP1_OFS: s_next.fcmp_sh[0] = merge16(s_reg.fcmp_sh[0], s_axi_wdata_i, s_axi_wstrb_i);
        FCMP2_OFS: s_next.fcmp_sh[1] = merge16(s_reg.fcmp_sh[1], s_axi_wdata_i, s_axi_wstrb_i);
        FCMP3_OFS: s_next.fcmp_sh[2] = merge16(s_reg.fcmp_sh[2], s_axi_wdata_i, s_axi_wstrb_i);
        OUTPUT_ACTION_REGISTER_OFS: s_next.output_action_register_sh = 12'(merge16({4'h0, s_reg.output_action_register_sh}, s_axi_wdata_i,
                                                s_axi_wstrb_i));
        DBCTL_OFS: s_next.dbctl = 11'(merge16({5'h00, s_reg.dbctl}, s_axi_wdata_i,
                                              s_axi_wstrb_i));
        CAPCTL_OFS: s_next.capctl = 11'(merge16({5'h00, s_reg.capctl}, s_axi_wdata_i,
                                                s_axi_wstrb_i));
        // an overflow in the same cycle survives the clear
        CAPSTAT_OFS:
          if (s_axi_wstrb_i[1]) s_next.fovf = s_next.fovf & ~(s_axi_wdata_i[8:6] & ~ovf); // RL23
        FLAG_OFS: clr = 12'(merge16(16'h0000, s_axi_wdata_i, s_axi_wstrb_i));
        MASK_OFS: s_next.mask = 12'(merge16({4'h0, s_reg.mask}, s_axi_wdata_i, s_axi_wstrb_i));
        CAPDAT1_OFS, CAPDAT2_OFS, CAPDAT3_OFS: s_next.bresp = RESP_OKAY;
        default: s_next.bresp = RESP_DECERR;
      endcase
    end

    // sticky flags: a new event wins over a clear in the same cycle
    s_next.flags = (s_reg.flags & ~clr) | set; // RL4
    s_next.irq = |(s_next.flags & s_reg.mask); // RL18
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_reg <= '0;
      s_reg.per_sh <= {PER_RST, PER_RST};
      s_reg.per_act <= {PER_RST, PER_RST};
      s_reg.up <= 2'h3;
      s_reg.cs0 <= 3'h0;
      s_reg.pdp_d <= 1'b1;
    end
    else s_reg <= s_next;
  end

  assign s_axi_awready_o = s_reg.awrdy;
  assign s_axi_wready_o = s_reg.wrdy;
  assign s_axi_bvalid_o = s_reg.bvalid;
  assign s_axi_bresp_o = s_reg.bresp;
  assign s_axi_arready_o = s_reg.arrdy;
  assign s_axi_rvalid_o = s_reg.rvalid;
  assign s_axi_rresp_o = s_reg.rresp;
  assign s_axi_rdata_o = s_reg.rdata;
  assign pwm_pair_o = s_reg.pwm;
  assign timer_pwm_o = s_reg.tpwm;
  assign irq_o = s_reg.irq;
endmodule : mev_event_block
`default_nettype wire

/* rtl/mev_pkg.sv */
// constants, register map and field layout of the motor event block
package mev_pkg;
  localparam int CLK_NS = 8;
  // register byte offsets
  localparam logic [7:0] T1_CNT_OFS = 8'h00;
  localparam logic [7:0] T1_CMP_OFS = 8'h04;
  localparam logic [7:0] T1_PER_OFS = 8'h08;
  localparam logic [7:0] T1_CTL_OFS = 8'h0C;
  localparam logic [7:0] T2_CNT_OFS = 8'h10;
  localparam logic [7:0] T2_CMP_OFS = 8'h14;
  localparam logic [7:0] T2_PER_OFS = 8'h18;
  localparam logic [7:0] T2_CTL_OFS = 8'h1C;
  localparam logic [7:0] FCMP1_OFS = 8'h20;
  localparam logic [7:0] FCMP2_OFS = 8'h24;
  localparam logic [7:0] FCMP3_OFS = 8'h28;
  localparam logic [7:0] OUTPUT_ACTION_REGISTER_OFS = 8'h2C;
  localparam logic [7:0] DBCTL_OFS = 8'h30;
  localparam logic [7:0] CAPCTL_OFS = 8'h34;
  localparam logic [7:0] CAPSTAT_OFS = 8'h38;
  localparam logic [7:0] CAPDAT1_OFS = 8'h3C;
  localparam logic [7:0] CAPDAT2_OFS = 8'h40;
  localparam logic [7:0] CAPDAT3_OFS = 8'h44;
  localparam logic [7:0] FLAG_OFS = 8'h48;
  localparam logic [7:0] MASK_OFS = 8'h4C;
  // timer_control_word fields
  localparam int TC_MODE_LSB = 0;
  localparam int TC_EXTCLK = 2;
  localparam int TC_PSC_LSB = 3;
  localparam int TC_ENABLE = 6;
  localparam int TC_OUT_EN = 7;
  localparam int TC_SYNC = 8;
  localparam int TC_POL_LSB = 9;
  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_CONT_UP = 2'h1;
  localparam logic [1:0] MODE_CONT_UPDN = 2'h2;
  localparam logic [1:0] MODE_DIR_UPDN = 2'h3;
  // deadband control and capture control fields
  localparam int DB_EN_LSB = 8;
  localparam int CC_EN_LSB = 6;
  localparam int CC_QEP = 9;
  localparam int CC_TB_T1 = 10;
  // event flag bits: timer 1 at 0, timer 2 at 4: underflow, overflow, compare, period
  localparam int FL_UNF = 0;
  localparam int FL_OVF = 1;
  localparam int FL_CMP = 2;
  localparam int FL_PER = 3;
  localparam int FL_PDP = 8;
  localparam int FL_CAP_LSB = 9;
  // reset values
  localparam logic [15:0] PER_RST = 16'hFFFF;
  localparam logic [15:0] ZERO16 = 16'h0000;
  // deadband timing
  localparam int DB_MAX_NS = 24000;
  localparam int DB_MIN_NS = 50;
  localparam int DB_MIN_CYC = (DB_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int DB_STEP_CYC = (DB_MAX_NS + 255 * CLK_NS - 1) / (255 * CLK_NS);
  localparam int DB_SUB_CYC = (DB_STEP_CYC > DB_MIN_CYC) ? DB_STEP_CYC : DB_MIN_CYC;
  localparam logic [3:0] DB_SUB_LAST = 4'(DB_SUB_CYC - 1);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : mev_pkg

/* test/mev_checker.sv */
// port checker for the motor event block
`timescale 1ns/1ps
`default_nettype none
module mev_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic power_protect_n_i,
  input wire logic [5:0] pwm_pair_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  write_take_a: assert property (
    s_axi_awready_o |-> s_axi_wready_o ##1 (!s_axi_awready_o && s_axi_bvalid_o))
    else $error("write handshake not followed by response");
  write_cause_a: assert property (
    $rose(s_axi_awready_o) |-> $past(s_axi_awvalid_i) && $past(s_axi_wvalid_i))
    else $error("write ready without both valids");
  bresp_hold_a: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  busy_write_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
    else $error("write taken while response pending");
  read_answer_a: assert property (
    s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read handshake not followed by data");
  rdata_hold_a: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data changed before taken");
  read_release_a: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read valid kept after accept");
  protect_off_a: assert property (
    $fell(power_protect_n_i) |-> ##[1:8] (pwm_pair_o == 6'h00))
    else $error("pwm pairs not shut off on protection");
  cover property (s_axi_bvalid_o && s_axi_bready_i);
  cover property (s_axi_rvalid_o && s_axi_rready_i);
  cover property ($fell(power_protect_n_i));
endmodule : mev_checker
bind mev_event_block mev_checker checker_u (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .power_protect_n_i(power_protect_n_i), .pwm_pair_o(pwm_pair_o)
);
`default_nettype wire

/* test/mev_source_model.sv */
// encoder, capture source and power stage model
`timescale 1ns/1ps
`default_nettype none
module mev_source_model (
  input wire logic clk_i,
  input wire logic step_i,
  input wire logic rev_i,
  input wire logic tgl_i,
  input wire logic fault_i,
  input wire logic [5:0] pwm_pair_i,
  output logic [2:0] capture_o,
  output logic power_protect_n_o,
  output int overlap_o,
  output int gap_o
);
  logic [1:0] phase = 2'h0;
  logic capture_input_3 = 1'h0;
  int hold = 0;
  int run = 0;
  initial power_protect_n_o = 1'h1;
  initial overlap_o = 0;
  initial gap_o = 1000;
  // quadrature pair: input 1 leads input 2 when moving forward
  assign capture_o = {capture_input_3, phase[1], phase[1] ^ phase[0]};
  always @(posedge clk_i)
  begin
    power_protect_n_o <= !fault_i;
    if (hold > 0)
      hold <= hold - 1;
    else if (step_i || tgl_i)
    begin
      hold <= 3;
      if (step_i)
        phase <= rev_i ? phase - 2'h1 : phase + 2'h1;
      if (tgl_i)
        capture_input_3 <= !capture_input_3;
    end
    // shoot-through and shortest dead zone seen on pair 1
    if (pwm_pair_i[0] && pwm_pair_i[1])
      overlap_o <= overlap_o + 1;
    if (pwm_pair_i[1:0] == 2'h0)
      run <= run + 1;
    else
    begin
      run <= 0;
      if (run > 0 && run < gap_o)
        gap_o <= run;
    end
  end
endmodule : mev_source_model
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the motor event block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mev_pkg::*;
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [7:0] aw_addr = 8'h00;
  logic [7:0] ar_addr = 8'h00;
  logic [31:0] w_data = 32'h0;
  logic aw_valid = 1'h0, w_valid = 1'h0, b_ready = 1'h0, ar_valid = 1'h0, r_ready = 1'h0;
  logic step = 1'h0, rev = 1'h0, tgl = 1'h0, fault = 1'h0;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid, pp_n, irq;
  logic [1:0] b_resp, r_resp, tpwm, rsp;
  logic [31:0] r_data, rd_val;
  logic [2:0] cap;
  logic [5:0] pwm;
  int num_errors = 0, n_compared = 0, overlap, gap;
  always #(CLK_NS / 2) clk_i = !clk_i;
  mev_event_block dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(aw_valid),
    .s_axi_awready_o(aw_ready), .s_axi_wdata_i(w_data), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(w_valid), .s_axi_wready_o(w_ready), .s_axi_bresp_o(b_resp),
    .s_axi_bvalid_o(b_valid), .s_axi_bready_i(b_ready), .s_axi_araddr_i(ar_addr),
    .s_axi_arvalid_i(ar_valid), .s_axi_arready_o(ar_ready), .s_axi_rdata_o(r_data),
    .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_valid), .s_axi_rready_i(r_ready),
    .timer_clk_ext_i(2'h0), .count_direction_input_i({!rev, 1'h1}), .power_protect_n_i(pp_n),
    .capture_input_i(cap), .pwm_pair_o(pwm), .timer_pwm_o(tpwm), .irq_o(irq)
  );
  mev_source_model src (
    .clk_i(clk_i), .step_i(step), .rev_i(rev), .tgl_i(tgl), .fault_i(fault),
    .pwm_pair_i(pwm), .capture_o(cap), .power_protect_n_o(pp_n), .overlap_o(overlap),
    .gap_o(gap)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'h1;
    w_valid <= 1'h1;
    do @(posedge clk_i); while (!(aw_ready && w_ready));
    aw_valid <= 1'h0;
    w_valid <= 1'h0;
    repeat ($urandom_range(2)) @(posedge clk_i);
    b_ready <= 1'h1;
    do @(posedge clk_i); while (!b_valid);
    b_ready <= 1'h0;
    rsp = b_resp;
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    ar_addr <= a;
    ar_valid <= 1'h1;
    do @(posedge clk_i); while (!ar_ready);
    ar_valid <= 1'h0;
    repeat ($urandom_range(2)) @(posedge clk_i);
    r_ready <= 1'h1;
    do @(posedge clk_i); while (!r_valid);
    r_ready <= 1'h0;
    rd_val = r_data;
    rsp = r_resp;
    @(posedge clk_i);
  endtask : rd
  task automatic kick(input logic s, input logic t);
    step <= s;
    tgl <= t;
    @(posedge clk_i);
    step <= 1'h0;
    tgl <= 1'h0;
    repeat (8) @(posedge clk_i);
  endtask : kick
  function automatic logic [31:0] t_ctl(input logic [1:0] m);
    return 32'(m) | (32'h1 << TC_ENABLE) | (32'h1 << TC_OUT_EN) | (32'h2 << TC_POL_LSB);
  endfunction : t_ctl
  function automatic int exp_fill(input int m, input int r, input int f);
    int n;
    n = (m % 2) * r + (m / 2) * f;
    return (n > 2) ? 2 : n;
  endfunction : exp_fill
  initial
  begin
    logic [15:0] v, p, c;
    int hi, k;
    v = 16'($urandom(30));
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'h1;
    @(posedge clk_i);
    rd(T1_PER_OFS);
    chk(rd_val, {16'h0000, PER_RST});
    wr(8'hFC, 32'h0000_1234);
    chk({30'h0, rsp}, {30'h0, RESP_DECERR});
    rd(8'hFC);
    chk({rd_val[29:0], rsp}, {30'h0, RESP_DECERR});
    v = 16'($urandom);
    wr(T2_CNT_OFS, {16'h0000, v});
    rd(T2_CNT_OFS);
    chk(rd_val, {16'h0000, v});
    p = 16'(60 + $urandom_range(30));
    c = 16'(p / 4 + $urandom_range(p / 2));
    wr(T1_PER_OFS, {16'h0000, p});
    wr(T1_CMP_OFS, {16'h0000, c});
    for (int u = 0; u < 3; u++)
      wr(FCMP1_OFS + 8'(4 * u), 32'(p / 4 + $urandom_range(p / 2)));
    wr(OUTPUT_ACTION_REGISTER_OFS, 32'h0000_0AAA);
    wr(DBCTL_OFS, 32'h0000_0700);
    wr(MASK_OFS, 32'h0);
    // start just below the wrap so the shadows load within two ticks
    wr(T1_CNT_OFS, 32'h0000_FFFE);
    wr(T1_CTL_OFS, t_ctl(MODE_CONT_UP));
    repeat (3 * p) @(posedge clk_i);
    hi = 0;
    repeat (p + 1)
    begin
      @(posedge clk_i);
      if (tpwm[0] === 1'h1)
        hi++;
    end
    chk(32'(hi), {16'h0000, c});
    chk(32'(overlap), 32'h0);
    chk({31'h0, gap >= DB_SUB_CYC}, 32'h1);
    rd(FLAG_OFS);
    chk(rd_val & 32'hF, 32'hF);
    chk({31'h0, irq}, 32'h0);
    wr(MASK_OFS, 32'h2);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    fault <= 1'h1;
    repeat (12) @(posedge clk_i);
    chk({24'h0, tpwm, pwm}, 32'h0);
    fault <= 1'h0;
    wr(T1_CTL_OFS, 32'h0);
    rd(FLAG_OFS);
    chk(rd_val & 32'h100, 32'h100);
    wr(FLAG_OFS, 32'hFFF);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    for (int m = 1; m < 4; m++)
    begin
      wr(CAPCTL_OFS, 32'(m << 4) | 32'h100);
      kick(1'h0, 1'h1);
      kick(1'h0, 1'h1);
      k = exp_fill(m, 1, 1);
      rd(CAPSTAT_OFS);
      chk(rd_val, 32'(k << 4));
      repeat (k)
      begin
        rd(CAPDAT3_OFS);
        chk(rd_val, {16'h0000, v});
      end
    end
    repeat (3) kick(1'h0, 1'h1);
    rd(CAPSTAT_OFS);
    chk(rd_val, 32'h120);
    wr(CAPSTAT_OFS, 32'h100);
    rd(CAPSTAT_OFS);
    chk(rd_val, 32'h20);
    rd(FLAG_OFS);
    chk(rd_val & 32'h800, 32'h800);
    wr(T2_CNT_OFS, 32'h0);
    wr(CAPCTL_OFS, 32'h200);
    wr(T2_CTL_OFS, 32'h43);
    k = 4 * $urandom_range(3, 1);
    repeat (k) kick(1'h1, 1'h0);
    rd(T2_CNT_OFS);
    chk(rd_val, 32'(k));
    rev <= 1'h1;
    repeat (k) kick(1'h1, 1'h0);
    rd(T2_CNT_OFS);
    chk(rd_val, 32'h0);
    // decoder off: timer 2 follows its direction pin, held low, so it wraps down to the period
    wr(CAPCTL_OFS, 32'h0);
    rd(FLAG_OFS);
    chk(rd_val & 32'hA0, 32'hA0);
    test_done();
  end
  initial
  begin
    // the sequence needs well under a fifth of this span
    repeat (50000) @(posedge clk_i);
    num_errors++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
